// File: rtl/strap_pkg.sv
/*
 Constants, types and register layout for the strap address loader.
 Assumes a single 125 MHz clock and a synchronous active-high reset.
*/
package strap_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int REG_ADDR_W = 5;
   localparam logic [4:0] PHY_CONTROL_OFF = 5'h19;
   localparam logic [4:0] STATUS_OFF = 5'h1A;
   localparam int ADDR_LSB = 0;
   localparam int ADDR_MSB = 4;
   localparam int ISO_BIT = 10;
   localparam logic [15:0] PHY_CONTROL_RST = 16'h0000;
   localparam logic [15:0] PHY_CONTROL_WMASK = 16'hFFE0;
   localparam logic [4:0] ISO_ADDR = 5'h00;
   localparam int SETTLE_NS = 64;
   localparam int CLK_NS = 8;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 8;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_RUN = 2'b11
   } load_state_t;

   typedef struct packed {
      logic [REG_ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic collision;
      logic transmit;
      logic receive;
      logic link;
      logic duplex_polarity;
   } indicator_t;
endpackage

// File: rtl/strap_sampler.sv
/*
 Strap sampler: waits for pins to settle, then captures five levels.
 Assumes pins are synchronous to the clock while released by the device.
*/
`timescale 1ns/1ps
module strap_sampler #(
   parameter int SETTLE = strap_pkg::SETTLE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Strap pins
   input wire logic [strap_pkg::ADDR_W-1:0] pins_in,
   // Result
   output logic [strap_pkg::ADDR_W-1:0] addr_out,
   output logic done_out
);
   logic [strap_pkg::CNT_W-1:0] cnt_reg;
   strap_pkg::load_state_t state_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= strap_pkg::ST_RESET;
         cnt_reg <= '0;
      end else begin
         case (state_reg)
            strap_pkg::ST_RESET: begin
               state_reg <= strap_pkg::ST_SAMPLE;
               cnt_reg <= '0;
            end
            strap_pkg::ST_SAMPLE: begin
               if (cnt_reg == strap_pkg::CNT_W'(SETTLE - 1)) begin
                  state_reg <= strap_pkg::ST_RUN;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            strap_pkg::ST_RUN: begin
               state_reg <= strap_pkg::ST_RUN;
            end
            default: begin
               state_reg <= strap_pkg::ST_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         addr_out <= '0;
         done_out <= 1'b0;
      end else if (state_reg == strap_pkg::ST_SAMPLE &&
                   cnt_reg == strap_pkg::CNT_W'(SETTLE - 1)) begin
         addr_out <= pins_in;
         done_out <= 1'b1;
      end
   end
endmodule // strap_sampler

// File: rtl/phy_address_strap_reset.sv
/*
 Top of the strap address loader: control register, isolation, pin mux.
 Assumes strap resistors set the pin levels while outputs are released,
 and that indicator sources come from elsewhere in the device.
*/
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module phy_address_strap_reset #(
   parameter int SETTLE = strap_pkg::SETTLE_CYC
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Register port
   input wire logic [strap_pkg::REG_ADDR_W-1:0] REG_ADDR,
   input wire logic [strap_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [strap_pkg::DATA_W-1:0] REG_RDATA,
   // Dual-purpose pins: strap in, indicator out
   input wire logic [strap_pkg::ADDR_W-1:0] STRAP_ADDRESS_PINS_IN,
   output logic [strap_pkg::ADDR_W-1:0] STRAP_ADDRESS_PINS_OUT,
   output logic [strap_pkg::ADDR_W-1:0] STRAP_ADDRESS_PINS_OE_N,
   // Indicator sources
   input wire strap_pkg::indicator_t INDICATORS,
   // Status to the rest of the device
   output logic [strap_pkg::ADDR_W-1:0] MGMT_ADDRESS,
   output logic ISOLATE,
   output logic MGMT_ENABLE,
   output logic STRAP_DONE
);
   strap_pkg::reg_req_t req;
   logic [strap_pkg::ADDR_W-1:0] sampled_addr;
   logic sample_done;
   logic done_d_reg;
   logic [strap_pkg::DATA_W-1:0] phy_control_reg;
   logic [strap_pkg::DATA_W-1:0] phy_control_next;
   logic [strap_pkg::ADDR_W-1:0] ind_vec;

   assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};
   assign ind_vec = {INDICATORS.duplex_polarity, INDICATORS.link,
                     INDICATORS.receive, INDICATORS.transmit,
                     INDICATORS.collision};

   ////////////////////////////////////////////////////////////////////
   strap_sampler #(
      .SETTLE(SETTLE)
   ) u_sampler (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .pins_in(STRAP_ADDRESS_PINS_IN),
      .addr_out(sampled_addr),
      .done_out(sample_done)
   );

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         done_d_reg <= 1'b0;
      end else begin
         done_d_reg <= sample_done;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control register: address field loaded by the strap, rest writable
   always_comb begin
      phy_control_next = phy_control_reg;
      if (req.wr && req.addr == strap_pkg::PHY_CONTROL_OFF) begin
         phy_control_next = (req.wdata & strap_pkg::PHY_CONTROL_WMASK) |
                            (phy_control_reg & ~strap_pkg::PHY_CONTROL_WMASK);
      end
      if (sample_done && !done_d_reg) begin
         phy_control_next[strap_pkg::ADDR_MSB:strap_pkg::ADDR_LSB] =
            sampled_addr;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         phy_control_reg <= strap_pkg::PHY_CONTROL_RST;
      end else begin
         phy_control_reg <= phy_control_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read port, one cycle latency
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         REG_RDATA <= '0;
      end else if (req.rd) begin
         case (req.addr)
            strap_pkg::PHY_CONTROL_OFF: begin
               REG_RDATA <= phy_control_reg;
            end
            strap_pkg::STATUS_OFF: begin
               REG_RDATA <= strap_pkg::DATA_W'({ISOLATE, MGMT_ADDRESS});
            end
            default: begin
               REG_RDATA <= '0;
            end
         endcase
      end else begin
         REG_RDATA <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Address, isolation and management enable
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         MGMT_ADDRESS <= '0;
         ISOLATE <= 1'b0;
         MGMT_ENABLE <= 1'b0;
         STRAP_DONE <= 1'b0;
      end else if (sample_done && !done_d_reg) begin
         MGMT_ADDRESS <= sampled_addr;
         ISOLATE <= (sampled_addr == strap_pkg::ISO_ADDR);
         MGMT_ENABLE <= 1'b1;
         STRAP_DONE <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pins released during sampling, then drive indicators
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         STRAP_ADDRESS_PINS_OUT <= '0;
         STRAP_ADDRESS_PINS_OE_N <= '1;
      end else if (sample_done) begin
         STRAP_ADDRESS_PINS_OUT <= ind_vec;
         STRAP_ADDRESS_PINS_OE_N <= '0;
      end else begin
         STRAP_ADDRESS_PINS_OUT <= '0;
         STRAP_ADDRESS_PINS_OE_N <= '1;
      end
   end
endmodule // phy_address_strap_reset

// File: bench/strap_board.sv
/* Board model: pull resistors on the strap pins.
   Assumes level holds the strap setting of each pin. */
`timescale 1ns/1ps
module strap_board (
   // Pin control
   input wire logic [4:0] oe_n,
   input wire logic [4:0] drive,
   // Strap setting and wire
   input wire logic [4:0] level,
   output logic [4:0] pins
);
   // Released pin goes to its pull level
   assign pins = (oe_n & level) | (~oe_n & drive);
endmodule // strap_board

// File: bench/strap_chk_sva.sv
/* Checker of strap loading and pin handover.
   Assumes binding to the loader top; sees its ports only. */
`timescale 1ns/1ps
module strap_chk_sva #(
   parameter int SETTLE = strap_pkg::SETTLE_CYC
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Observed
   input wire logic REG_RD,
   input wire logic [15:0] REG_RDATA,
   input wire logic [4:0] STRAP_ADDRESS_PINS_IN,
   input wire logic [4:0] STRAP_ADDRESS_PINS_OUT,
   input wire logic [4:0] STRAP_ADDRESS_PINS_OE_N,
   input wire strap_pkg::indicator_t INDICATORS,
   input wire logic [4:0] MGMT_ADDRESS,
   input wire logic ISOLATE,
   input wire logic MGMT_ENABLE,
   input wire logic STRAP_DONE
);
   logic [7:0] cyc_reg;
   logic [4:0] ind_reg;
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST)
         cyc_reg <= 8'h00;
      else if (cyc_reg != 8'hFF)
         cyc_reg <= cyc_reg + 8'h01;
   end
   always_ff @(posedge SYS_CLK) begin
      ind_reg <= {INDICATORS.duplex_polarity, INDICATORS.link,
         INDICATORS.receive, INDICATORS.transmit, INDICATORS.collision};
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   a_done_time: assert property (STRAP_DONE == (cyc_reg >= SETTLE + 2))
      else $error("strap done at wrong time");
   a_load_pins: assert property ($rose(STRAP_DONE) |->
      MGMT_ADDRESS == $past(STRAP_ADDRESS_PINS_IN, 2)) else $error("bad load");
   a_addr_hold: assert property (STRAP_DONE && $past(STRAP_DONE) |->
      $stable(MGMT_ADDRESS)) else $error("address moved");
   a_iso_zero: assert property (ISOLATE ==
      (STRAP_DONE && MGMT_ADDRESS == 5'h00)) else $error("bad isolate");
   a_mgmt_on: assert property (MGMT_ENABLE == STRAP_DONE)
      else $error("bad mgmt enable");
   a_oe_release: assert property (STRAP_ADDRESS_PINS_OE_N ==
      {5{!STRAP_DONE}}) else $error("bad pin enable");
   a_ind_drive: assert property (STRAP_DONE |->
      STRAP_ADDRESS_PINS_OUT == ind_reg) else $error("bad indicator");
   a_rst_init: assert property ($past(SYS_RST) |-> !STRAP_DONE &&
      MGMT_ADDRESS == 5'h00 && REG_RDATA == 16'h0000) else $error("bad init");
   a_rdata_idle: assert property (!$past(REG_RD) |->
      REG_RDATA == 16'h0000) else $error("read data outside read cycle");
endmodule // strap_chk_sva
bind phy_address_strap_reset strap_chk_sva #(.SETTLE(SETTLE)) i_chk (
   .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA),
   .STRAP_ADDRESS_PINS_IN(STRAP_ADDRESS_PINS_IN),
   .STRAP_ADDRESS_PINS_OUT(STRAP_ADDRESS_PINS_OUT),
   .STRAP_ADDRESS_PINS_OE_N(STRAP_ADDRESS_PINS_OE_N),
   .INDICATORS(INDICATORS), .MGMT_ADDRESS(MGMT_ADDRESS), .ISOLATE(ISOLATE),
   .MGMT_ENABLE(MGMT_ENABLE), .STRAP_DONE(STRAP_DONE));

// File: bench/tb.sv
/* Bench top: boots the loader under several strap settings.
   Assumes the board model sets the pin levels. */
`timescale 1ns/1ps
module tb;
   logic clk = 0, rst = 1, wr = 0, rd = 0;
   logic [4:0] ra = 0, lvl = 0;
   logic [15:0] wd = 0;
   strap_pkg::indicator_t ind = '0;
   logic [15:0] rdat;
   logic [4:0] pins, pout, oe_n, maddr;
   logic iso, men, done;
   int miscompares = 0, checks_done = 0;
   logic [4:0] lvl_tab [6] = '{5'h00, 5'h1F, 5'h15, 5'h01, 5'h10, 5'h0A};
   initial forever #4 clk = ~clk;
   phy_address_strap_reset #(.SETTLE(2)) i_dut (.SYS_CLK(clk), .SYS_RST(rst),
      .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
      .REG_RDATA(rdat), .STRAP_ADDRESS_PINS_IN(pins),
      .STRAP_ADDRESS_PINS_OUT(pout), .STRAP_ADDRESS_PINS_OE_N(oe_n),
      .INDICATORS(ind), .MGMT_ADDRESS(maddr), .ISOLATE(iso),
      .MGMT_ENABLE(men), .STRAP_DONE(done));
   strap_board i_board (.oe_n(oe_n), .drive(pout), .level(lvl), .pins(pins));
   task automatic results;
      if (miscompares == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   task automatic acc(logic w, logic [4:0] a, logic [15:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   task automatic boot(logic [4:0] a);
      @(posedge clk);
      lvl <= a;
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 40 && done !== 1'b1; i++) @(posedge clk);
      #1;
      if (done !== 1'b1) begin
         miscompares++;
         results;
      end
   endtask
   task automatic sc_strap(logic [4:0] a);
      boot(a);
      chk("address", 16'(a), 16'(maddr));
      chk("isolate", 16'(a == 5'h00), 16'(iso));
      chk("mgmt", 16'h0001, 16'(men));
      acc(1'b0, 5'h19, 16'h0000);
      chk("ctrl", 16'(a), rdat);
      acc(1'b0, 5'h1A, 16'h0000);
      chk("status", {10'h000, a == 5'h00, a}, rdat);
   endtask
   task automatic sc_write;
      acc(1'b1, 5'h19, 16'hFFFF);
      acc(1'b1, 5'h1A, 16'hFFFF);
      acc(1'b0, 5'h19, 16'h0000);
      chk("ctrl wr", 16'hFFEA, rdat);
      acc(1'b0, 5'h03, 16'h0000);
      chk("unmapped", 16'h0000, rdat);
      @(posedge clk);
      lvl <= 5'h15;
      ind <= 5'h0D;
      repeat (3) @(posedge clk);
      #1;
      chk("held", 16'h000A, 16'(maddr));
      chk("pins", 16'h0016, 16'(pins));
      boot(5'h0A);
      acc(1'b0, 5'h19, 16'h0000);
      chk("ctrl rst", 16'h000A, rdat);
   endtask
   initial begin
      foreach (lvl_tab[k])
         sc_strap(lvl_tab[k]);
      sc_write;
      results;
   end
endmodule // tb
